// File: fdi_drive_ctrl.sv
// Drive-side control of a 5.25-inch flexible disk drive behind its 34-line host bus.
// Assumes the host lines and sensors are asynchronous, and straps are static after power-up.
`timescale 1ns/1ps
// Notes on behaviour
// - Motor request low spins spindle up, at speed within 250 ms.
// - Motor request high stops the spindle within 150 ms.
// - Motor request acts whether or not the unit is selected.
// - Latch closure runs the motor about five seconds unless motor requested.
// - A selected low step pulse over 200 ns moves the head one track.
// - Direction sampled per step: low moves inward, high outward.
// - Head movement starts on the rising, trailing edge of step.
// - Step ignored when writing, outward at zero, deselected, past 79, latch open.
// - Selected and writing, each write data falling edge makes one flux reversal.
// - Write gate low enables write current, disables read; high turns writing off.
// - Protected diskette keeps writing off regardless of gate and side.
// - Side input high uses lower head, low uses upper head.
// - Index low about 4 ms per revolution; sectors merged for hard-sectored media.
// - Selected at track zero, track-zero output is low, released when moved.
// - Protected diskette drives protect output low; host should not write then.
// - Selected, each flux transition gives a 1 us low read pulse.
// - Four strap ready modes; some need select toggled to re-establish ready.
// - Straps are read only at power-up.
// - Straps bind to unit 0 to 3, unit 3 on two pins, or always selected.
// - Deselected unit ignores control inputs except motor request; releases all status outputs but a read pulse already begun.
// - One ready mode needs latch closure only, no select toggle.
module fdi_drive_ctrl
  import fdi_pkg::*;
#(
  parameter int unsigned SPINUP_CYCLES = fdi_pkg::SPINUP_CYC,
  parameter int unsigned STOP_CYCLES = fdi_pkg::STOP_CYC,
  parameter int unsigned LATCH_RUN_CYCLES = fdi_pkg::LATCH_RUN_CYC,
  parameter int unsigned INDEX_CYCLES = fdi_pkg::INDEX_CYC
) (
  input wire logic CORE_CLK,
  input wire logic RST_N,
  input wire fdi_pkg::fdi_host_s HOST_IN,
  input wire fdi_pkg::fdi_media_s MEDIA_IN,
  input wire fdi_pkg::fdi_strap_s STRAPS,
  input wire logic FLUX_IN_VALID,
  input wire logic FLUX_IN_SIDE,
  output logic FLUX_IN_READY,
  output fdi_pkg::fdi_status_s HOST_OUT,
  output fdi_pkg::fdi_drive_s DRIVE_OUT
);
  import fdi_pkg::*;

  logic rst_ok;
  fdi_host_s h;
  fdi_media_s m;
  fdi_strap_s sy_straps;
  fdi_state_s s_reg;
  fdi_state_s s_next;
  logic selected;
  logic write_ok;
  logic demand;
  logic hole;
  fdi_ready_e rdy_mode;

  fdi_sync #(.W(1), .RST_VAL(1'b0)) u_rst_sync (
    .clk(CORE_CLK),
    .rst_n(RST_N),
    .d(1'b1),
    .q(rst_ok)
  );

  fdi_sync #(.W(26), .RST_VAL({HOST_IDLE, 6'h00, 9'h000})) u_pin_sync (
    .clk(CORE_CLK),
    .rst_n(rst_ok),
    .d({HOST_IN, MEDIA_IN, STRAPS}),
    .q({h, m, sy_straps})
  );

  // Unit decode from captured straps only, so a strap moved while powered has no effect
  assign selected = s_reg.straps_taken & (s_reg.straps.always_selected_strap
    | (s_reg.straps.unit_zero_strap & !h.sel0_n)
    | (s_reg.straps.unit_one_strap & !h.sel1_n)
    | (s_reg.straps.unit_two_strap & !h.sel2_n)
    | (s_reg.straps.unit_three_strap & s_reg.straps.unit_three_main_pin_strap & !h.sel3_main_n)
    | (s_reg.straps.unit_three_strap & s_reg.straps.unit_three_alt_pin_strap & !h.sel3_alt_n));
  assign write_ok = selected & !h.wgate_n & !m.wp_sense;
  assign demand = !h.motor_on_n | (s_reg.latch_cnt != 32'h0);
  assign hole = m.index_hole | (m.hard_sector & m.sector_hole);
  assign rdy_mode = fdi_ready_e'({s_reg.straps.ready_mode_strap_a, s_reg.straps.ready_mode_strap_b});

  always_comb begin
    logic step_rise;
    logic pop;
    logic push;
    logic rdy;
    step_rise = 1'b0;
    pop = 1'b0;
    push = 1'b0;
    rdy = 1'b0;
    s_next = s_reg;
    s_next.drive.step_pulse = 1'b0;
    s_next.drive.flux_write = 1'b0;

    // Straps caught once, a few cycles after reset release so the synchroniser has settled
    if (!s_reg.straps_taken) begin
      if (s_reg.strap_cnt == STRAP_WAIT) begin
        s_next.straps_taken = 1'b1;
        s_next.straps = sy_straps;
      end else begin
        s_next.strap_cnt = s_reg.strap_cnt + 2'h1;
      end
    end

    // Step: measure the low width, act on the trailing edge
    step_rise = !s_reg.step_prev & h.step_n;
    s_next.step_prev = h.step_n;
    if (h.step_n) begin
      s_next.step_low_cnt = 5'h00;
    end else if (s_reg.step_low_cnt != 5'h1f) begin
      s_next.step_low_cnt = s_reg.step_low_cnt + 5'h01;
    end
    if (step_rise && s_reg.step_low_cnt >= STEP_MIN_CYC && selected && h.wgate_n && m.latch_closed) begin
      if (!h.dir_n && s_reg.drive.track != LAST_TRACK) begin
        s_next.drive.track = s_reg.drive.track + 7'h01;
        s_next.drive.step_pulse = 1'b1;
        s_next.drive.step_inward = 1'b1;
      end else if (h.dir_n && s_reg.drive.track != 7'h00) begin
        s_next.drive.track = s_reg.drive.track - 7'h01;
        s_next.drive.step_pulse = 1'b1;
        s_next.drive.step_inward = 1'b0;
      end
    end

    // Write path
    s_next.drive.write_current = write_ok;
    s_next.drive.read_en = !write_ok;
    s_next.wdata_prev = h.wdata_n;
    s_next.drive.flux_write = write_ok & s_reg.wdata_prev & !h.wdata_n;
    if (selected) begin
      s_next.drive.head_upper = !h.side_n;
    end

    // Latch-started spin; edges count only once straps are in, so a latch shut at power-up is no closure
    s_next.latch_prev = m.latch_closed;
    if (s_reg.straps_taken && !s_reg.latch_prev && m.latch_closed) begin
      s_next.latch_cnt = LATCH_RUN_CYCLES;
    end else if (s_reg.latch_cnt != 32'h0) begin
      s_next.latch_cnt = s_reg.latch_cnt - 32'h1;
    end

    // Spindle sequencing
    case (s_reg.mot)
      MOT_STOPPED: begin
        if (demand) begin
          s_next.mot = MOT_SPINUP;
          s_next.mot_cnt = SPINUP_CYCLES - 32'h1;
        end
      end
      MOT_SPINUP: begin
        if (!demand) begin
          s_next.mot = MOT_SPINDOWN;
          s_next.mot_cnt = STOP_CYCLES - 32'h1;
        end else if (s_reg.mot_cnt == 32'h0) begin
          s_next.mot = MOT_RUNNING;
        end else begin
          s_next.mot_cnt = s_reg.mot_cnt - 32'h1;
        end
      end
      MOT_RUNNING: begin
        if (!demand) begin
          s_next.mot = MOT_SPINDOWN;
          s_next.mot_cnt = STOP_CYCLES - 32'h1;
        end
      end
      MOT_SPINDOWN: begin
        if (demand) begin
          s_next.mot = MOT_SPINUP;
          s_next.mot_cnt = SPINUP_CYCLES - 32'h1;
        end else if (s_reg.mot_cnt == 32'h0) begin
          s_next.mot = MOT_STOPPED;
        end else begin
          s_next.mot_cnt = s_reg.mot_cnt - 32'h1;
        end
      end
      default: begin
        s_next.mot = MOT_STOPPED;
      end
    endcase
    s_next.drive.motor_run = (s_next.mot == MOT_SPINUP) | (s_next.mot == MOT_RUNNING);
    s_next.drive.at_speed = (s_next.mot == MOT_RUNNING);

    // Index stretcher; each hole edge gives one fixed-width low pulse
    s_next.hole_prev = hole;
    if (s_reg.straps_taken && !s_reg.hole_prev && hole) begin
      s_next.idx_cnt = INDEX_CYCLES;
      s_next.idx_seen = 1'b1;
    end else if (s_reg.idx_cnt != 32'h0) begin
      s_next.idx_cnt = s_reg.idx_cnt - 32'h1;
    end
    if (s_next.mot == MOT_STOPPED) begin
      s_next.idx_seen = 1'b0;
    end

    // Change flag: a latch opening wins over a reselect in the same cycle
    s_next.sel_prev = selected;
    s_next.disk_changed = (s_reg.latch_prev & !m.latch_closed)
      | (s_reg.disk_changed & !(selected & !s_reg.sel_prev));

    case (rdy_mode)
      RDY_DISK: rdy = m.latch_closed & m.disk_present & !s_reg.disk_changed;
      RDY_LATCH: rdy = m.latch_closed;
      RDY_DISK_SPEED: rdy = m.latch_closed & m.disk_present & !s_reg.disk_changed & s_reg.idx_seen
        & s_reg.drive.at_speed;
      RDY_LATCH_SPEED: rdy = m.latch_closed & s_reg.idx_seen & s_reg.drive.at_speed;
      default: rdy = 1'b0;
    endcase

    // Two-entry flux buffer; the pulse generator drains it and stalls while busy
    push = FLUX_IN_VALID & s_reg.flux_ready;
    pop = (s_reg.rd_cnt == 7'h00) & (s_reg.buf_cnt != 2'h0);
    if (s_reg.rd_cnt != 7'h00) begin
      s_next.rd_cnt = s_reg.rd_cnt - 7'h01;
    end
    if (pop && selected && s_reg.buf_side[0] == s_reg.drive.head_upper) begin
      s_next.rd_cnt = RD_CYC;
    end
    case ({push, pop})
      2'b10: begin
        s_next.buf_side[s_reg.buf_cnt[0]] = FLUX_IN_SIDE;
        s_next.buf_cnt = s_reg.buf_cnt + 2'h1;
      end
      2'b01: begin
        s_next.buf_side[0] = s_reg.buf_side[1];
        s_next.buf_cnt = s_reg.buf_cnt - 2'h1;
      end
      2'b11: begin
        if (s_reg.buf_cnt == 2'h1) begin
          s_next.buf_side[0] = FLUX_IN_SIDE;
        end else begin
          s_next.buf_side[0] = s_reg.buf_side[1];
          s_next.buf_side[1] = FLUX_IN_SIDE;
        end
      end
      default: begin
      end
    endcase
    s_next.flux_ready = (s_next.buf_cnt != BUF_DEPTH);

    // Status lines other than read data are released while deselected
    s_next.status.index_n = !(selected & (s_next.idx_cnt != 32'h0));
    s_next.status.track0_n = !(selected & (s_next.drive.track == 7'h00));
    s_next.status.protect_n = !(selected & m.wp_sense);
    s_next.status.rdata_n = !(s_next.rd_cnt != 7'h00);
    s_next.status.ready_n = !(selected & rdy);
  end

  always_ff @(posedge CORE_CLK or negedge rst_ok) begin
    if (!rst_ok) begin
      s_reg <= '{mot: MOT_STOPPED, status: STATUS_IDLE, disk_changed: 1'b1, step_prev: 1'b1, wdata_prev: 1'b1,
        drive: '{read_en: 1'b1, default: '0}, default: '0};
    end else begin
      s_reg <= s_next;
    end
  end

  assign HOST_OUT = s_reg.status;
  assign DRIVE_OUT = s_reg.drive;
  assign FLUX_IN_READY = s_reg.flux_ready;

  default clocking cb @(posedge CORE_CLK);
  endclocking
  default disable iff (!rst_ok);

  sequence valid_step_seq;
    $rose(h.step_n) && s_reg.step_low_cnt >= STEP_MIN_CYC && selected && h.wgate_n && m.latch_closed;
  endsequence

  sequence rd_pulse_seq;
    s_reg.rd_cnt == RD_CYC ##1 s_reg.rd_cnt == RD_CYC - 7'h01 && !s_reg.status.rdata_n;
  endsequence

  chk_step_inward: assert property (valid_step_seq and !h.dir_n && s_reg.drive.track != LAST_TRACK
    |=> s_reg.drive.step_pulse && s_reg.drive.step_inward && s_reg.drive.track == $past(s_reg.drive.track) + 7'h01)
    else $error("inward step not taken");
  chk_step_deselect: assert property (!selected |=> !s_reg.drive.step_pulse)
    else $error("step taken while deselected");
  chk_track_limit: assert property (s_reg.drive.track <= LAST_TRACK)
    else $error("track beyond last");
  chk_step_moves: assert property (s_reg.drive.step_pulse |-> s_reg.drive.track != $past(s_reg.drive.track))
    else $error("step pulse without movement");
  chk_write_protect: assert property (m.wp_sense |=> !s_reg.drive.write_current && s_reg.drive.read_en)
    else $error("write current with protected disk");
  chk_flux_write: assert property (write_ok && $fell(h.wdata_n) |=> s_reg.drive.flux_write)
    else $error("write edge lost");
  chk_read_pulse: assert property ($fell(s_reg.status.rdata_n) |-> rd_pulse_seq)
    else $error("read pulse wrong width");
  chk_motor_request: assert property (!h.motor_on_n |=> s_reg.drive.motor_run)
    else $error("motor request ignored");
  chk_motor_stop: assert property (h.motor_on_n && s_reg.latch_cnt == 32'h0 && s_reg.mot == MOT_RUNNING
    |=> s_reg.mot == MOT_SPINDOWN && !s_reg.drive.motor_run)
    else $error("motor did not stop");
  chk_track_zero: assert property (!s_reg.status.track0_n |-> s_reg.drive.track == 7'h00)
    else $error("track zero flag wrong");
  chk_buf_full: assert property (s_reg.buf_cnt == BUF_DEPTH |-> !FLUX_IN_READY)
    else $error("ready while buffer full");

  sequence hole_edge_seq;
    !s_reg.hole_prev && hole && s_reg.straps_taken;
  endsequence

  chk_step_outward: assert property (valid_step_seq and h.dir_n && s_reg.drive.track != 7'h00
    |=> s_reg.drive.step_pulse && !s_reg.drive.step_inward && s_reg.drive.track == $past(s_reg.drive.track) - 7'h01)
    else $error("outward step not taken");
  chk_step_short: assert property ($rose(h.step_n) && s_reg.step_low_cnt < STEP_MIN_CYC
    |=> !s_reg.drive.step_pulse)
    else $error("short step taken");
  chk_step_trailing: assert property (s_reg.drive.step_pulse |-> $past(h.step_n) && !$past(h.step_n, 2))
    else $error("step not on trailing edge");
  chk_step_wgate: assert property (!h.wgate_n |=> !s_reg.drive.step_pulse)
    else $error("step taken while writing");
  chk_step_latch: assert property (!m.latch_closed |=> !s_reg.drive.step_pulse)
    else $error("step taken with latch open");
  chk_write_on: assert property (write_ok |=> s_reg.drive.write_current && !s_reg.drive.read_en)
    else $error("write current not enabled");
  chk_write_off: assert property (h.wgate_n |=> !s_reg.drive.write_current && s_reg.drive.read_en)
    else $error("write current with gate off");
  chk_flux_idle: assert property (!write_ok |=> !s_reg.drive.flux_write)
    else $error("flux reversal while write disabled");
  chk_head_side: assert property (selected |=> s_reg.drive.head_upper == !$past(h.side_n))
    else $error("head does not follow side input");
  chk_index_start: assert property (hole_edge_seq and selected |=> !s_reg.status.index_n)
    else $error("index pulse missing");
  chk_protect_out: assert property (selected && m.wp_sense |=> !s_reg.status.protect_n)
    else $error("protect output not driven");
  chk_disk_change: assert property (s_reg.latch_prev && !m.latch_closed |=> s_reg.disk_changed)
    else $error("latch opening not recorded");
  chk_desel_status: assert property (!selected
    |=> s_reg.status.index_n && s_reg.status.track0_n && s_reg.status.protect_n && s_reg.status.ready_n)
    else $error("status driven while deselected");
  chk_motor_latch: assert property (s_reg.latch_cnt != 32'h0 |=> s_reg.drive.motor_run)
    else $error("latch run did not start motor");
  chk_ready_latch: assert property (rdy_mode == RDY_LATCH && selected && m.latch_closed
    |=> !s_reg.status.ready_n)
    else $error("ready not given on latch alone");
endmodule

// File: fdi_pkg.sv
// Shared types and constants for the flexible disk drive interface control block.
// Assumes a 100 MHz core clock; pin-side lines are active low as on the ribbon bus.
package fdi_pkg;

  localparam int unsigned CLK_PERIOD_NS = 10;
  localparam int unsigned SPINUP_MS = 250;
  localparam int unsigned STOP_MS = 150;
  localparam int unsigned LATCH_RUN_S = 5;
  localparam int unsigned INDEX_MS = 4;
  localparam int unsigned STEP_MIN_NS = 200;
  localparam int unsigned RD_PULSE_NS = 1000;

  // Longest times round down, least times round up
  localparam int unsigned SPINUP_CYC = SPINUP_MS * 1000000 / CLK_PERIOD_NS;
  localparam int unsigned STOP_CYC = STOP_MS * 1000000 / CLK_PERIOD_NS;
  localparam int unsigned LATCH_RUN_CYC = LATCH_RUN_S * 1000 * (1000000 / CLK_PERIOD_NS);
  localparam int unsigned INDEX_CYC = INDEX_MS * 1000000 / CLK_PERIOD_NS;
  localparam logic [4:0] STEP_MIN_CYC = 5'((STEP_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam logic [6:0] RD_CYC = 7'(RD_PULSE_NS / CLK_PERIOD_NS);

  localparam logic [6:0] LAST_TRACK = 7'h4f;
  localparam logic [1:0] STRAP_WAIT = 2'h3;
  localparam logic [1:0] BUF_DEPTH = 2'h2;

  typedef struct packed {
    logic sel0_n;
    logic sel1_n;
    logic sel2_n;
    logic sel3_main_n;
    logic sel3_alt_n;
    logic motor_on_n;
    logic dir_n;
    logic step_n;
    logic wdata_n;
    logic wgate_n;
    logic side_n;
  } fdi_host_s;

  typedef struct packed {
    logic latch_closed;
    logic wp_sense;
    logic disk_present;
    logic index_hole;
    logic sector_hole;
    logic hard_sector;
  } fdi_media_s;

  typedef struct packed {
    logic unit_zero_strap;
    logic unit_one_strap;
    logic unit_two_strap;
    logic unit_three_strap;
    logic always_selected_strap;
    logic unit_three_alt_pin_strap;
    logic unit_three_main_pin_strap;
    logic ready_mode_strap_a;
    logic ready_mode_strap_b;
  } fdi_strap_s;

  typedef struct packed {
    logic index_n;
    logic track0_n;
    logic protect_n;
    logic rdata_n;
    logic ready_n;
  } fdi_status_s;

  typedef struct packed {
    logic motor_run;
    logic at_speed;
    logic step_pulse;
    logic step_inward;
    logic flux_write;
    logic write_current;
    logic read_en;
    logic head_upper;
    logic [6:0] track;
  } fdi_drive_s;

  typedef enum logic [1:0] {
    MOT_STOPPED = 2'b00,
    MOT_SPINUP = 2'b01,
    MOT_RUNNING = 2'b10,
    MOT_SPINDOWN = 2'b11
  } fdi_motor_e;

  typedef enum logic [1:0] {
    RDY_DISK = 2'b00,
    RDY_LATCH = 2'b01,
    RDY_DISK_SPEED = 2'b10,
    RDY_LATCH_SPEED = 2'b11
  } fdi_ready_e;

  localparam fdi_host_s HOST_IDLE = 11'h7ff;
  localparam fdi_status_s STATUS_IDLE = 5'h1f;

  typedef struct packed {
    logic [1:0] strap_cnt;
    logic straps_taken;
    fdi_strap_s straps;
    logic step_prev;
    logic wdata_prev;
    logic latch_prev;
    logic hole_prev;
    logic sel_prev;
    logic [4:0] step_low_cnt;
    fdi_motor_e mot;
    logic [31:0] mot_cnt;
    logic [31:0] latch_cnt;
    logic [31:0] idx_cnt;
    logic idx_seen;
    logic disk_changed;
    logic [1:0] buf_side;
    logic [1:0] buf_cnt;
    logic flux_ready;
    logic [6:0] rd_cnt;
    fdi_status_s status;
    fdi_drive_s drive;
  } fdi_state_s;

endpackage

// File: fdi_sync.sv
// Two-flop synchroniser for a vector of levels, also used to release the reset.
// Assumes each bit is a slow level; multi-bit values are not kept coherent.
`timescale 1ns/1ps
module fdi_sync #(
  parameter int W = 1,
  parameter logic [W-1:0] RST_VAL = '0
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);
  logic [W-1:0] meta_reg;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      meta_reg <= RST_VAL;
      q <= RST_VAL;
    end else begin
      meta_reg <= d;
      q <= meta_reg;
    end
  end
endmodule

// File: fdi_ctl_model.sv
// Behavioural floppy controller driving the direction, step and write data lines.
// Assumes the bench calls its tasks 1 ns after a rising clock edge.
`timescale 1ns/1ps
module fdi_ctl_model (
  input wire logic clk,
  output logic dir_n,
  output logic step_n,
  output logic wdata_n
);
  initial begin
    dir_n = 1'b1;
    step_n = 1'b1;
    wdata_n = 1'b1;
  end
  // Direction settles two cycles before the pulse and is held well after its trailing edge
  task automatic step(input logic inward, input int low_cyc);
    dir_n = !inward;
    repeat (2) @(posedge clk);
    #1 step_n = 1'b0;
    repeat (low_cyc) @(posedge clk);
    #1 step_n = 1'b1;
    // Spacing scaled far below 3 ms to keep the run short; the drive does not rely on it
    repeat (30) @(posedge clk);
    #1;
  endtask
  // Falling edges at a steady rate, as double-frequency data would give
  task automatic write_edges(input int n);
    repeat (n) begin
      wdata_n = 1'b0;
      repeat (3) @(posedge clk);
      #1 wdata_n = 1'b1;
      repeat (3) @(posedge clk);
      #1;
    end
  endtask
endmodule

// File: tb.sv
// Self-checking bench for the drive control block, with a controller model on the step lines.
// Assumes shortened motor, latch and index counts set at the instance.
`timescale 1ns/1ps
module tb;
  import fdi_pkg::*;
  localparam int SPIN = 50, STOP = 30, LRUN = 200, IDX = 40;
  logic clk, rst_n, fv, fs, fr, inw, dir_n, step_n, wdata_n;
  fdi_host_s h, host_in;
  fdi_media_s m;
  fdi_strap_s s;
  fdi_status_s st;
  fdi_drive_s d;
  int n_mismatch, comparisons, seed, t, pt, k, e, w;
  // Monitor counters start at zero here so that only the monitor process ever writes them
  int rd_run = 0, rd_w = 0, rd_n = 0, ix_run = 0, ix_w = 0, ix_n = 0, fw_n = 0, sp_n = 0;

  fdi_ctl_model u_ctl (.clk(clk), .dir_n(dir_n), .step_n(step_n), .wdata_n(wdata_n));
  fdi_drive_ctrl #(.SPINUP_CYCLES(SPIN), .STOP_CYCLES(STOP), .LATCH_RUN_CYCLES(LRUN), .INDEX_CYCLES(IDX)) u_dut (
    .CORE_CLK(clk), .RST_N(rst_n), .HOST_IN(host_in), .MEDIA_IN(m), .STRAPS(s), .FLUX_IN_VALID(fv),
    .FLUX_IN_SIDE(fs), .FLUX_IN_READY(fr), .HOST_OUT(st), .DRIVE_OUT(d));

  always_comb begin
    host_in = h;
    host_in.dir_n = dir_n;
    host_in.step_n = step_n;
    host_in.wdata_n = wdata_n;
  end

  // Pulse widths are timed from the falling edge, the controller's reference
  always @(posedge clk) begin
    if (st.rdata_n === 1'b0) rd_run <= rd_run + 1;
    else if (rd_run != 0) begin
      rd_w <= rd_run;
      rd_n <= rd_n + 1;
      rd_run <= 0;
    end
    if (st.index_n === 1'b0) ix_run <= ix_run + 1;
    else if (ix_run != 0) begin
      ix_w <= ix_run;
      ix_n <= ix_n + 1;
      ix_run <= 0;
    end
    if (d.flux_write === 1'b1) fw_n <= fw_n + 1;
    if (d.step_pulse === 1'b1) sp_n <= sp_n + 1;
  end

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  task automatic chk(input string nm, input logic [31:0] ex, input logic [31:0] got);
    comparisons++;
    if (got !== ex) begin
      $display("ERROR %s expected %h seen %h", nm, ex, got);
      n_mismatch++;
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic done(input string nm);
    $display("End of test %s", nm);
  endtask
  task automatic push(input logic side);
    fv = 1'b1;
    fs = side;
    for (int i = 0; i < 300 && fr !== 1'b1; i++) cyc(1);
    cyc(1);
  endtask
  task automatic hole(input logic sector);
    if (sector) m.sector_hole = 1'b1;
    else m.index_hole = 1'b1;
    cyc(5);
    m.sector_hole = 1'b0;
    m.index_hole = 1'b0;
    cyc(IDX + 10);
  endtask
  task automatic print_verdict();
    $display("Checks %0d mismatches %0d", comparisons, n_mismatch);
    if (n_mismatch == 0 && comparisons > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask

  // Refused and out-of-range steps leave the track where it was
  function automatic int exp_track(input int tr, input logic inward, input int width);
    if (width < 20) return tr;
    if (inward) return (tr < 79) ? tr + 1 : tr;
    return (tr > 0) ? tr - 1 : tr;
  endfunction

  initial begin
    repeat (60000) @(posedge clk);
    n_mismatch++;
    print_verdict();
  end

  initial begin
    {n_mismatch, comparisons} = '0;
    seed = 4492;
    rst_n = 1'b0;
    h = HOST_IDLE;
    m = '0;
    m.latch_closed = 1'b1;
    m.disk_present = 1'b1;
    s = '0;
    s.unit_one_strap = 1'b1;
    s.ready_mode_strap_b = 1'b1;
    fv = 1'b0;
    fs = 1'b0;
    cyc(3);
    chk("status_rst", STATUS_IDLE, st);
    chk("drive_rst", 15'h0100, d);
    chk("fifo_ready_rst", 0, fr);
    cyc(2);
    rst_n = 1'b1;
    cyc(10);
    s.unit_one_strap = 1'b0;
    s.unit_two_strap = 1'b1;
    h.sel1_n = 1'b0;
    cyc(4);
    chk("track0", 0, st.track0_n);
    chk("ready", 0, st.ready_n);
    chk("fifo_ready", 1, fr);
    done("select");
    h.sel1_n = 1'b1;
    h.sel2_n = 1'b0;
    cyc(4);
    chk("track0_desel", 1, st.track0_n);
    chk("ready_desel", 1, st.ready_n);
    u_ctl.step(1'b1, 25);
    chk("track_desel", 0, d.track);
    h.sel2_n = 1'b1;
    h.sel1_n = 1'b0;
    done("deselect");
    t = 0;
    e = 0;
    for (k = 0; k < 16; k++) begin
      inw = (k == 0) ? 1'b0 : 1'($random(seed) & 1);
      w = (($random(seed) & 3) == 0) ? 12 : 25;
      u_ctl.step(inw, w);
      pt = t;
      t = exp_track(t, inw, w);
      if (t != pt) e++;
      chk("track", t, d.track);
    end
    fork
      u_ctl.step(1'b1, 60);
      begin
        cyc(45);
        chk("track_while_low", t, d.track);
      end
    join
    t++;
    chk("step_inward", 1, d.step_inward);
    e = e + 1 + 79 - t;
    for (k = 0; k < 80; k++) u_ctl.step(1'b1, 25);
    chk("track_top", 79, d.track);
    chk("track0_away", 1, st.track0_n);
    chk("step_pulses", e, sp_n);
    done("step");
    h.wgate_n = 1'b0;
    u_ctl.step(1'b0, 25);
    chk("track_wgate", 79, d.track);
    chk("wr_current", 1, d.write_current);
    chk("read_en_wr", 0, d.read_en);
    k = fw_n;
    u_ctl.write_edges(5);
    chk("flux_writes", k + 5, fw_n);
    m.wp_sense = 1'b1;
    cyc(4);
    chk("wr_current_wp", 0, d.write_current);
    chk("protect", 0, st.protect_n);
    k = fw_n;
    u_ctl.write_edges(3);
    chk("flux_writes_wp", k, fw_n);
    m.wp_sense = 1'b0;
    h.wgate_n = 1'b1;
    cyc(4);
    chk("wr_current_off", 0, d.write_current);
    chk("read_en", 1, d.read_en);
    done("write");
    m.latch_closed = 1'b0;
    cyc(4);
    u_ctl.step(1'b0, 25);
    chk("track_latch", 79, d.track);
    m.latch_closed = 1'b1;
    cyc(5);
    chk("motor_latch", 1, d.motor_run);
    cyc(LRUN + 4);
    chk("motor_latch_end", 0, d.motor_run);
    h.sel1_n = 1'b1;
    h.motor_on_n = 1'b0;
    cyc(4);
    chk("motor_on", 1, d.motor_run);
    chk("not_at_speed", 0, d.at_speed);
    cyc(SPIN);
    chk("at_speed", 1, d.at_speed);
    h.motor_on_n = 1'b1;
    cyc(4);
    chk("motor_off", 0, d.motor_run);
    cyc(STOP + 2);
    chk("stopped", 0, d.at_speed);
    h.sel1_n = 1'b0;
    done("motor");
    for (k = 0; k < 4; k++) begin
      h.side_n = 1'($random(seed) & 1);
      cyc(4);
      chk("head_upper", !h.side_n, d.head_upper);
    end
    h.side_n = 1'b1;
    cyc(4);
    k = rd_n;
    repeat (3) push(1'b0);
    fv = 1'b0;
    cyc(2);
    chk("fifo_full", 0, fr);
    e = 3;
    repeat (4) begin
      inw = 1'($random(seed) & 1);
      if (!inw) e++;
      push(inw);
    end
    fv = 1'b0;
    cyc(900);
    chk("read_pulses", k + e, rd_n);
    chk("read_width", 100, rd_w);
    done("read");
    k = ix_n;
    hole(1'b0);
    chk("index_pulses", k + 1, ix_n);
    chk("index_width", IDX, ix_w);
    hole(1'b1);
    chk("sector_soft", k + 1, ix_n);
    m.hard_sector = 1'b1;
    hole(1'b1);
    chk("sector_hard", k + 2, ix_n);
    done("index");
    print_verdict();
  end
endmodule
